//--- hdl/adc_cfg_pkg.sv
// Contract
// - three-wire by default; config bit 7 enables the dedicated output line.
// - in four-wire mode the dedicated output is driven even when unselected.
// - serial clock low before select falls; first rise starts the instruction.
// - instruction: top bit read/write, two count bits, 13-bit start address.
// - count field 00..10 means 1..3 bytes, 11 means stream until deselect.
// - most significant bit first; config bit 6 makes all data lsb first.
// - multi-byte address increments in msb-first order, decrements in lsb-first.
// - data bytes follow the instruction while select is low and clock runs.
// - short transfers pause at byte boundaries; streams only before first data.
// - writing config bit 5 restores port registers to defaults.
// - burst last address register ends a stream at that address.
// - read-only die identifier and revision registers at fixed addresses.
// - converter index resets to zero; one converter selected at a time.
// - indexed register read with no converter selected returns byte ad.
// - offset trims are 8-bit, defaulting to calibration result; reset here loads mid-scale 80 instead.
// - coarse gain holds four weighted bits; medium and fine gain are 8-bit.
// - power codes 000 pin, 001 normal, 010 nap, 100 sleep; survive soft reset.
// - port power setting overrides the pin, per selected converter.
package adc_cfg_pkg;

   localparam int ADDR_W = 13;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [12:0] ADDR_PORT_CFG    = 13'h000;
   localparam logic [12:0] ADDR_BURST_LAST  = 13'h002;
   localparam logic [12:0] ADDR_DIE_ID      = 13'h008;
   localparam logic [12:0] ADDR_DIE_REV     = 13'h009;
   localparam logic [12:0] ADDR_CONV_SEL    = 13'h010;
   localparam logic [12:0] ADDR_OFS_COARSE  = 13'h020;
   localparam logic [12:0] ADDR_OFS_FINE    = 13'h021;
   localparam logic [12:0] ADDR_GAIN_COARSE = 13'h022;
   localparam logic [12:0] ADDR_GAIN_MEDIUM = 13'h023;
   localparam logic [12:0] ADDR_GAIN_FINE   = 13'h024;
   localparam logic [12:0] ADDR_POWER_MODE  = 13'h025;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CFG_FOUR_WIRE_BIT  = 7;
   localparam int CFG_LSB_FIRST_BIT  = 6;
   localparam int CFG_SOFT_RESET_BIT = 5;
   localparam int INSTR_READ_BIT     = 15;
   localparam int INSTR_COUNT_HI     = 14;
   localparam int INSTR_COUNT_LO     = 13;

   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [7:0] PORT_CFG_RST    = 8'h18;
   localparam logic [7:0] BURST_LAST_RST  = 8'h00;
   localparam logic [7:0] CONV_SEL_RST    = 8'h00;
   localparam logic [7:0] TRIM_RST        = 8'h80;
   localparam logic [3:0] GAIN_COARSE_RST = 4'h0;
   localparam logic [7:0] INDEX_ERROR     = 8'had;
   localparam logic [1:0] COUNT_STREAM    = 2'h3;

   localparam logic [2:0] PWR_PIN    = 3'h0;
   localparam logic [2:0] PWR_NORMAL = 3'h1;
   localparam logic [2:0] PWR_NAP    = 3'h2;
   localparam logic [2:0] PWR_SLEEP  = 3'h4;

   // resolved tri-level pin: 00 normal, 01 sleep, 10 nap
   localparam logic [1:0] PIN_SLEEP = 2'h1;
   localparam logic [1:0] PIN_NAP   = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} port_state_t;

endpackage

//--- hdl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_q   <= RESET_VAL;
         sync_out <= RESET_VAL;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // pin_sync
`default_nettype wire

//--- hdl/adc_spi_config_port.sv
`timescale 1ns/10ps
`default_nettype none
module adc_spi_config_port
   import adc_cfg_pkg::*;
#(
   parameter int         NUM_CONV = 2,
   parameter logic [7:0] DIE_ID   = 8'h5a,  // arbitrary value
   parameter logic [7:0] DIE_REV  = 8'h01   // arbitrary value
) (
   input  wire logic                     ref_clk,
   input  wire logic                     arst_n,
   input  wire logic                     sclk,
   input  wire logic                     port_select_n,
   input  wire logic                     sdio_in,
   output logic                          sdio_out,
   output logic                          sdio_oe,
   output logic                          dedicated_serial_out,
   output logic                          dedicated_serial_oe,
   input  wire logic [1:0]               power_mode_pin,
   output logic [NUM_CONV-1:0][7:0]      offset_coarse,
   output logic [NUM_CONV-1:0][7:0]      offset_fine,
   output logic [NUM_CONV-1:0][3:0]      gain_coarse,
   output logic [NUM_CONV-1:0][7:0]      gain_medium,
   output logic [NUM_CONV-1:0][7:0]      gain_fine,
   output logic [NUM_CONV-1:0][2:0]      power_mode
);

   if (NUM_CONV < 1 || NUM_CONV > 8)
   begin : g_bad_conv
      $error("NUM_CONV must be 1 to 8");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
         r[i] = b[7-i];
      return r;
   endfunction

   function automatic logic [12:0] step(input logic [12:0] a, input logic down);
      return down ? 13'(a - 13'h001) : 13'(a + 13'h001);
   endfunction

   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   logic [4:0] sync_w;
   logic       sclk_s;
   logic       sel_n_s;
   logic       sdio_s;
   logic [1:0] pin_s;

   pin_sync #(
      .WIDTH     (5),
      .RESET_VAL (5'h02)
   ) u_pin_sync (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .async_in ({power_mode_pin, sdio_in, port_select_n, sclk}),
      .sync_out (sync_w)
   );

   assign sclk_s  = sync_w[0];
   assign sel_n_s = sync_w[1];
   assign sdio_s  = sync_w[2];
   assign pin_s   = sync_w[4:3];

   logic sclk_prev_q;
   logic sel_n_prev_q;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sclk_prev_q  <= 1'b0;
         sel_n_prev_q <= 1'b1;
      end
      else
      begin
         sclk_prev_q  <= sclk_s;
         sel_n_prev_q <= sel_n_s;
      end
   end

   logic active;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_rise;

   assign active    = ~sel_n_s;
   assign sclk_rise = sclk_s & ~sclk_prev_q & active;
   assign sclk_fall = ~sclk_s & sclk_prev_q & active;
   assign sel_rise  = sel_n_s & ~sel_n_prev_q;

   // ----------------------------------------------------------------
   // registers and decode
   // ----------------------------------------------------------------
   port_state_t state_q;
   logic [3:0]  bit_cnt_q;
   logic [15:0] shift_q;
   logic        read_q;
   logic [1:0]  count_q;
   logic [1:0]  left_q;
   logic        data_seen_q;
   logic [12:0] addr_q;
   logic [7:0]  tx_q;
   logic        out_q;

   logic [7:0] cfg_q;
   logic [7:0] burst_q;
   logic [7:0] sel_q;
   logic [NUM_CONV-1:0][7:0] ofs_c_q;
   logic [NUM_CONV-1:0][7:0] ofs_f_q;
   logic [NUM_CONV-1:0][3:0] gain_c_q;
   logic [NUM_CONV-1:0][7:0] gain_m_q;
   logic [NUM_CONV-1:0][7:0] gain_f_q;
   logic [NUM_CONV-1:0][2:0] pwr_q;
   logic [NUM_CONV-1:0][2:0] pwr_out_q;

   logic        four_wire;
   logic        lsb_first;
   logic [15:0] shift_nx;
   logic [15:0] instr_word;
   logic [7:0]  rx_byte;
   logic [12:0] addr_nx;
   logic [12:0] rd_addr;
   logic [7:0]  rd_data;
   logic        instr_end;
   logic        data_end;
   logic        wr_en;
   logic        soft_rst;
   logic        last_byte;
   logic        sel_ok;
   logic [2:0]  sel_idx;

   assign four_wire = cfg_q[CFG_FOUR_WIRE_BIT];
   assign lsb_first = cfg_q[CFG_LSB_FIRST_BIT];
   assign shift_nx  = {shift_q[14:0], sdio_s};
   // lsb-first reverses the whole 16-bit instruction and each data byte
   assign instr_word = lsb_first ? {rev8(shift_nx[7:0]), rev8(shift_nx[15:8])}
                                 : shift_nx;
   assign rx_byte    = lsb_first ? rev8(shift_nx[7:0]) : shift_nx[7:0];
   assign addr_nx    = step(addr_q, lsb_first);

   assign instr_end = sclk_rise && state_q == ST_INSTR && bit_cnt_q == 4'hf;
   assign data_end  = sclk_rise && state_q == ST_DATA && bit_cnt_q == 4'h7;
   assign wr_en     = data_end & ~read_q;
   assign soft_rst  = wr_en && addr_q == ADDR_PORT_CFG && rx_byte[CFG_SOFT_RESET_BIT];

   // zero in the burst register means no address limit
   always_comb
   begin
      if (count_q == COUNT_STREAM)
         last_byte = burst_q != 8'h00 && addr_q == {5'h00, burst_q};
      else
         last_byte = left_q == 2'h0;
   end

   // lowest set index bit wins, so only one converter is ever addressed
   always_comb
   begin
      sel_ok  = 1'b0;
      sel_idx = 3'h0;
      for (int i = NUM_CONV - 1; i >= 0; i--)
      begin
         if (sel_q[i])
         begin
            sel_ok  = 1'b1;
            sel_idx = 3'(i);
         end
      end
   end

   // next byte to send: start address after the instruction, else the stepped one
   assign rd_addr = (state_q == ST_INSTR) ? instr_word[12:0] : addr_nx;

   always_comb
   begin
      rd_data = 8'h00;
      case (rd_addr)
         ADDR_PORT_CFG   : rd_data = cfg_q;
         ADDR_BURST_LAST : rd_data = burst_q;
         ADDR_DIE_ID     : rd_data = DIE_ID;
         ADDR_DIE_REV    : rd_data = DIE_REV;
         ADDR_CONV_SEL   : rd_data = sel_q;
         ADDR_OFS_COARSE, ADDR_OFS_FINE, ADDR_GAIN_COARSE,
         ADDR_GAIN_MEDIUM, ADDR_GAIN_FINE, ADDR_POWER_MODE :
         begin
            if (!sel_ok)
               rd_data = INDEX_ERROR;
            else if (rd_addr == ADDR_OFS_COARSE)
               rd_data = ofs_c_q[sel_idx];
            else if (rd_addr == ADDR_OFS_FINE)
               rd_data = ofs_f_q[sel_idx];
            else if (rd_addr == ADDR_GAIN_COARSE)
               rd_data = {4'h0, gain_c_q[sel_idx]};
            else if (rd_addr == ADDR_GAIN_MEDIUM)
               rd_data = gain_m_q[sel_idx];
            else if (rd_addr == ADDR_GAIN_FINE)
               rd_data = gain_f_q[sel_idx];
            else
               rd_data = {5'h00, pwr_q[sel_idx]};
         end
         default         : rd_data = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // transfer sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q     <= ST_IDLE;
         bit_cnt_q   <= 4'h0;
         shift_q     <= 16'h0000;
         read_q      <= 1'b0;
         count_q     <= 2'h0;
         left_q      <= 2'h0;
         data_seen_q <= 1'b0;
         addr_q      <= 13'h0000;
         tx_q        <= 8'h00;
      end
      else if (sel_rise)
      begin
         // pause only at a byte edge, and a stream only before its first data
         if (state_q == ST_DONE || bit_cnt_q[2:0] != 3'h0 ||
             (state_q == ST_DATA && count_q == COUNT_STREAM && data_seen_q))
         begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
         end
      end
      else if (sclk_rise)
      begin
         unique case (state_q)
            ST_IDLE :
            begin
               state_q   <= ST_INSTR;
               shift_q   <= shift_nx;
               bit_cnt_q <= 4'h1;
            end
            ST_INSTR :
            begin
               shift_q   <= shift_nx;
               bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
               if (instr_end)
               begin
                  read_q      <= instr_word[INSTR_READ_BIT];
                  count_q     <= instr_word[INSTR_COUNT_HI:INSTR_COUNT_LO];
                  left_q      <= instr_word[INSTR_COUNT_HI:INSTR_COUNT_LO];
                  addr_q      <= instr_word[12:0];
                  tx_q        <= rd_data;
                  data_seen_q <= 1'b0;
                  bit_cnt_q   <= 4'h0;
                  state_q     <= ST_DATA;
               end
            end
            ST_DATA :
            begin
               shift_q     <= shift_nx;
               data_seen_q <= 1'b1;
               bit_cnt_q   <= 4'(bit_cnt_q + 4'h1);
               if (data_end)
               begin
                  bit_cnt_q <= 4'h0;
                  if (last_byte)
                     state_q <= ST_DONE;
                  else
                  begin
                     addr_q <= addr_nx;
                     left_q <= 2'(left_q - 2'h1);
                     tx_q   <= rd_data;
                  end
               end
            end
            ST_DONE : ;
         endcase
      end
   end

   // read data changes on falling serial clock, sampled by master on rising
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         out_q <= 1'b0;
      else if (sclk_fall && state_q == ST_DATA && read_q)
         out_q <= tx_q[lsb_first ? bit_cnt_q[2:0] : 3'(3'h7 - bit_cnt_q[2:0])];
   end

   assign sdio_out             = out_q;
   assign sdio_oe              = ~four_wire & active & read_q & (state_q == ST_DATA);
   assign dedicated_serial_out = out_q;
   assign dedicated_serial_oe  = four_wire;

   // ----------------------------------------------------------------
   // port registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_q   <= PORT_CFG_RST;
         burst_q <= BURST_LAST_RST;
         sel_q   <= CONV_SEL_RST;
      end
      else if (soft_rst)
      begin
         cfg_q   <= PORT_CFG_RST;
         burst_q <= BURST_LAST_RST;
         sel_q   <= CONV_SEL_RST;
      end
      else if (wr_en)
      begin
         if (addr_q == ADDR_PORT_CFG)
            cfg_q <= rx_byte;
         if (addr_q == ADDR_BURST_LAST)
            burst_q <= rx_byte;
         if (addr_q == ADDR_CONV_SEL)
            sel_q <= rx_byte;
      end
   end

   // 8-bit trims reset to mid-scale, coarse gain to zero; calibration loading is outside this block
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ofs_c_q  <= {NUM_CONV{TRIM_RST}};
         ofs_f_q  <= {NUM_CONV{TRIM_RST}};
         gain_c_q <= {NUM_CONV{GAIN_COARSE_RST}};
         gain_m_q <= {NUM_CONV{TRIM_RST}};
         gain_f_q <= {NUM_CONV{TRIM_RST}};
      end
      else if (soft_rst)
      begin
         ofs_c_q  <= {NUM_CONV{TRIM_RST}};
         ofs_f_q  <= {NUM_CONV{TRIM_RST}};
         gain_c_q <= {NUM_CONV{GAIN_COARSE_RST}};
         gain_m_q <= {NUM_CONV{TRIM_RST}};
         gain_f_q <= {NUM_CONV{TRIM_RST}};
      end
      else if (wr_en && sel_ok)
      begin
         if (addr_q == ADDR_OFS_COARSE)
            ofs_c_q[sel_idx] <= rx_byte;
         if (addr_q == ADDR_OFS_FINE)
            ofs_f_q[sel_idx] <= rx_byte;
         if (addr_q == ADDR_GAIN_COARSE)
            gain_c_q[sel_idx] <= rx_byte[3:0];
         if (addr_q == ADDR_GAIN_MEDIUM)
            gain_m_q[sel_idx] <= rx_byte;
         if (addr_q == ADDR_GAIN_FINE)
            gain_f_q[sel_idx] <= rx_byte;
      end
   end

   // power mode keeps its value through soft reset
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         pwr_q <= {NUM_CONV{PWR_PIN}};
      else if (wr_en && sel_ok && addr_q == ADDR_POWER_MODE)
         pwr_q[sel_idx] <= rx_byte[2:0];
   end

   logic [2:0] pin_code;

   always_comb
   begin
      if (pin_s == PIN_SLEEP)
         pin_code = PWR_SLEEP;
      else if (pin_s == PIN_NAP)
         pin_code = PWR_NAP;
      else
         pin_code = PWR_NORMAL;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         pwr_out_q <= {NUM_CONV{PWR_NORMAL}};
      else
         for (int i = 0; i < NUM_CONV; i++)
            pwr_out_q[i] <= (pwr_q[i] == PWR_PIN) ? pin_code : pwr_q[i];
   end

   assign offset_coarse = ofs_c_q;
   assign offset_fine   = ofs_f_q;
   assign gain_coarse   = gain_c_q;
   assign gain_medium   = gain_m_q;
   assign gain_fine     = gain_f_q;
   assign power_mode    = pwr_out_q;

endmodule // adc_spi_config_port
`default_nettype wire

//--- tb/adc_spi_config_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adc_spi_config_port_monitor #(
   parameter int NUM_CONV = 2
) (
   input wire logic                     ref_clk,
   input wire logic                     arst_n,
   input wire logic                     sclk,
   input wire logic                     port_select_n,
   input wire logic [1:0]               power_mode_pin,
   input wire logic                     sdio_out,
   input wire logic                     sdio_oe,
   input wire logic                     dedicated_serial_out,
   input wire logic                     dedicated_serial_oe,
   input wire logic [NUM_CONV-1:0][7:0] offset_coarse,
   input wire logic [NUM_CONV-1:0][7:0] offset_fine,
   input wire logic [NUM_CONV-1:0][3:0] gain_coarse,
   input wire logic [NUM_CONV-1:0][7:0] gain_medium,
   input wire logic [NUM_CONV-1:0][7:0] gain_fine,
   input wire logic [NUM_CONV-1:0][2:0] power_mode
);
   // ------------------------------------------------------------
   // port checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   chk_wire_mode_excl: assert property (sdio_oe |-> !dedicated_serial_oe)
      else $error("both data lines driven");
   chk_idle_release: assert property (port_select_n [*8] |-> !sdio_oe)
      else $error("data line driven while unselected");
   chk_same_bit: assert property (sdio_out == dedicated_serial_out)
      else $error("output lines disagree");
   chk_mode_codes: assert property ($onehot(power_mode[0]) && $onehot(power_mode[NUM_CONV-1]))
      else $error("power mode code illegal");
   // read bits move only while the serial clock has been low a while
   chk_bit_timing: assert property ($changed(sdio_out) && $past(sdio_oe) |-> !$past(sclk, 3))
      else $error("read bit moved off the falling edge");
   chk_trim_quiet: assert property (port_select_n [*8] |->
      $stable({offset_coarse, offset_fine, gain_coarse, gain_medium, gain_fine}))
      else $error("trim changed without a transfer");
   chk_dso_stable: assert property (port_select_n [*8] |-> $stable(dedicated_serial_oe))
      else $error("output enable moved while unselected");
   chk_power_quiet: assert property ((port_select_n && $stable(power_mode_pin)) [*8] |->
      $stable(power_mode))
      else $error("power mode changed without cause");
endmodule // adc_spi_config_port_monitor

bind adc_spi_config_port adc_spi_config_port_monitor #(.NUM_CONV(NUM_CONV)) mon (
   .ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk), .port_select_n(port_select_n),
   .power_mode_pin(power_mode_pin), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
   .dedicated_serial_out(dedicated_serial_out), .dedicated_serial_oe(dedicated_serial_oe),
   .offset_coarse(offset_coarse), .offset_fine(offset_fine), .gain_coarse(gain_coarse),
   .gain_medium(gain_medium), .gain_fine(gain_fine), .power_mode(power_mode));
`default_nettype wire

//--- tb/spi_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
   input  wire logic ref_clk,
   input  wire logic sdio_out,
   input  wire logic sdio_oe,
   input  wire logic dedicated_serial_out,
   input  wire logic dedicated_serial_oe,
   output logic      sclk,
   output logic      port_select_n,
   output logic      sdio_in
);
   // ------------------------------------------------------------
   // serial master
   // ------------------------------------------------------------
   localparam int HALF = 10;
   logic drv;
   logic bit_q;

   initial
   begin
      sclk = 1'b0;
      port_select_n = 1'b1;
      drv = 1'b0;
      bit_q = 1'b0;
   end

   // released line shows the inverse so a stale bit never reads back
   assign sdio_in = sdio_oe ? sdio_out : (drv ? bit_q : ~bit_q);

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic sel(input logic v);
      @(posedge ref_clk);
      sclk <= 1'b0;
      idle(HALF);
      port_select_n <= v;
      drv <= 1'b0;
      idle(HALF);
   endtask

   task automatic open_frame();
      sel(1'b0);
   endtask

   task automatic close_frame();
      sel(1'b1);
   endtask

   // no extra edge between bits, so one serial period is two halves
   task automatic shift(input logic [7:0] tx, input logic lsb, input logic rd,
                        output logic [7:0] rx);
      logic b;
      for (int i = 0; i < 8; i++)
      begin
         sclk <= 1'b0;
         drv <= ~rd;
         bit_q <= lsb ? tx[i] : tx[7-i];
         idle(HALF);
         b = dedicated_serial_oe ? dedicated_serial_out : sdio_in;
         rx[lsb ? i : 7-i] = b;
         sclk <= 1'b1;
         idle(HALF);
      end
   endtask
endmodule // spi_master_model
`default_nettype wire

//--- tb/adc_spi_config_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module adc_spi_config_port_tb;
   import adc_cfg_pkg::*;

   typedef struct packed {logic we; logic [12:0] a; logic [7:0] d; logic [7:0] e;} row_t;

   logic             ref_clk = 1'b0;
   logic             arst_n = 1'b0;
   logic [1:0]       power_mode_pin = 2'h0;
   logic             sclk, port_select_n, sdio_in, sdio_out, sdio_oe, dso, dso_oe;
   logic [1:0][7:0]  ofs_c, ofs_f, gn_m, gn_f;
   logic [1:0][3:0]  gn_c;
   logic [1:0][2:0]  pwr;
   logic             lsb_mode = 1'b0;
   logic [31:0]      rx;
   logic [7:0]       v;
   int               errors = 0;
   int               cmp_count = 0;
   int               cyc = 0;
   row_t             rows [11] = '{
      '{1'b1, 13'h010, 8'h01, 8'h01}, '{1'b1, 13'h020, 8'h3c, 8'h3c},
      '{1'b1, 13'h021, 8'hc3, 8'hc3}, '{1'b1, 13'h022, 8'h0a, 8'h0a},
      '{1'b1, 13'h023, 8'h11, 8'h11}, '{1'b1, 13'h024, 8'hee, 8'hee},
      '{1'b1, 13'h025, 8'h01, 8'h01}, '{1'b1, 13'h002, 8'h00, 8'h00},
      '{1'b0, 13'h008, 8'h00, 8'h3b}, '{1'b0, 13'h009, 8'h00, 8'h07},
      '{1'b0, 13'h0f0, 8'h00, 8'h00}};

   always #2 ref_clk = ~ref_clk;

   adc_spi_config_port #(.NUM_CONV(2), .DIE_ID(8'h3b), .DIE_REV(8'h07)) dut ( // arbitrary ids
      .ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk), .port_select_n(port_select_n),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .dedicated_serial_out(dso), .dedicated_serial_oe(dso_oe),
      .power_mode_pin(power_mode_pin), .offset_coarse(ofs_c), .offset_fine(ofs_f),
      .gain_coarse(gn_c), .gain_medium(gn_m), .gain_fine(gn_f), .power_mode(pwr));

   spi_master_model m (
      .ref_clk(ref_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .dedicated_serial_out(dso), .dedicated_serial_oe(dso_oe),
      .sclk(sclk), .port_select_n(port_select_n), .sdio_in(sdio_in));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [12:0] a,
                       input int n, input logic [31:0] tx, output logic [31:0] r);
      logic [15:0] ins;
      logic [47:0] frame;
      logic [7:0]  b;
      r = '0;
      ins = {rd, cnt, a};
      frame = {tx, lsb_mode ? ins[15:8] : ins[7:0], lsb_mode ? ins[7:0] : ins[15:8]};
      m.open_frame();
      for (int i = 0; i < n + 2; i++)
      begin
         m.shift(frame[8*i +: 8], lsb_mode, rd && i > 1, b);
         if (i > 1)
            r[8*(i-2) +: 8] = b;
      end
      m.close_frame();
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(1'b0, 2'h0, a, 1, {24'h0, d}, r);
   endtask

   task automatic rd(input logic [12:0] a, output logic [7:0] d);
      logic [31:0] r;
      xfer(1'b1, 2'h0, a, 1, 32'h0, r);
      d = r[7:0];
   endtask

   task automatic pulse_reset();
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask

   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         errors++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      pulse_reset();
      power_mode_pin <= 2'h1;
      repeat (8) @(posedge ref_clk);
      chk(8'(pwr[1]), 8'(PWR_SLEEP));
      power_mode_pin <= 2'h0;
      foreach (rows[i])
      begin
         if (rows[i].we)
            wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         chk(v, rows[i].e);
      end
      chk(ofs_c[0], 8'h3c);
      chk(8'(gn_c[0]), 8'h0a);
      $display("test table done");
      // stream cut short by the last address register
      wr(13'h002, 8'h22);
      xfer(1'b0, 2'h3, 13'h020, 4, 32'h44332211, rx);
      chk(ofs_c[0], 8'h11);
      chk(ofs_f[0], 8'h22);
      chk(8'(gn_c[0]), 8'h03);
      chk(gn_m[0], 8'h11);
      wr(13'h002, 8'h00);
      // fourth byte lies past the count: line released, model shows ones
      xfer(1'b1, 2'h2, 13'h020, 4, 32'h0, rx);
      chk(rx[7:0], 8'h11);
      chk(rx[15:8], 8'h22);
      chk(rx[23:16], 8'h03);
      chk(rx[31:24], 8'hff);
      $display("test stream done");
      // stream pause: allowed before first data, aborts after it
      xfer(1'b0, 2'h3, 13'h023, 1, 32'h55, rx);
      xfer(1'b0, 2'h3, 13'h024, 0, 32'h0, rx);
      m.open_frame();
      m.shift(8'h66, lsb_mode, 1'b0, v);
      m.close_frame();
      chk(gn_m[0], 8'h55);
      chk(gn_f[0], 8'h66);
      wr(13'h010, 8'h00);
      rd(13'h020, v);
      chk(v, INDEX_ERROR);
      $display("test abort and index done");
      wr(13'h010, 8'h01);
      wr(13'h025, 8'h02);
      wr(13'h010, 8'h02);
      wr(13'h025, 8'h02);
      chk(8'(pwr[0]), 8'(PWR_NAP));
      chk(8'(pwr[1]), 8'(PWR_NAP));
      wr(13'h000, 8'h3c);
      rd(13'h000, v);
      chk(v, PORT_CFG_RST);
      chk(ofs_c[0], TRIM_RST);
      chk(8'(pwr[0]), 8'(PWR_NAP));
      // only nap is left here; a sleep exit would need a millisecond pause
      wr(13'h010, 8'h01);
      wr(13'h025, 8'h01);
      wr(13'h010, 8'h02);
      wr(13'h025, 8'h01);
      chk(8'(pwr[0]), 8'(PWR_NORMAL));
      chk(8'(pwr[1]), 8'(PWR_NORMAL));
      $display("test nap and soft reset done");
      wr(13'h010, 8'h01);
      wr(13'h000, 8'h5a);
      lsb_mode = 1'b1;
      xfer(1'b0, 2'h1, 13'h021, 2, 32'h7799, rx);
      chk(ofs_f[0], 8'h99);
      chk(ofs_c[0], 8'h77);
      rd(13'h008, v);
      chk(v, 8'h3b);
      wr(13'h000, 8'h18);
      lsb_mode = 1'b0;
      $display("test lsb first done");
      wr(13'h000, 8'h99);
      repeat (8) @(posedge ref_clk);
      chk(8'(dso_oe), 8'h01);
      rd(13'h009, v);
      chk(v, 8'h07);
      wr(13'h000, 8'h18);
      repeat (8) @(posedge ref_clk);
      chk(8'(dso_oe), 8'h00);
      $display("test four wire done");
      pulse_reset();
      chk(ofs_c[1], TRIM_RST);
      chk(8'(pwr[0]), 8'(PWR_NORMAL));
      power_mode_pin <= 2'h2;
      repeat (8) @(posedge ref_clk);
      chk(8'(pwr[0]), 8'(PWR_NAP));
      rd(13'h000, v);
      chk(v, PORT_CFG_RST);
      rd(13'h010, v);
      chk(v, CONV_SEL_RST);
      $display("test reset done");
      report_and_stop();
   end
endmodule // adc_spi_config_port_tb
`default_nettype wire
